// *** rtl/sfq_host.sv ***
// APB-commanded host that runs one flash command over the four data lines
`timescale 1ns/100ps
module sfq_host (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic cs_n_out,
  output logic sclk_out,
  input wire logic [3:0] data_line_in,
  output logic [3:0] data_line_out,
  output logic [3:0] data_line_oe_n_out
);

  sfq_pkg::sfq_ctrl_s ctrl_reg;
  logic [23:0] addr_reg;
  logic [7:0] mode_reg;
  logic [31:0] wdata_reg;
  logic done_reg;
  logic [31:0] prdata_reg;
  logic [3:0] line_meta_reg;
  logic [3:0] line_sync_reg;
  logic [3:0] div_reg;
  logic tick;
  sfq_pkg::sfq_phase_e state_reg;
  sfq_pkg::sfq_phase_e state_next;
  logic sclk_reg;
  logic cs_n_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [5:0] bits_reg;
  logic [5:0] bits_next;
  logic [31:0] rx_reg;
  logic [31:0] rx_next;
  logic done_pulse_reg;
  logic [3:0] out_reg;
  logic [3:0] oe_n_reg;
  logic [3:0] out_val;
  logic [3:0] oe_n_val;
  logic [5:0] lanes;
  logic dtr_phase;
  logic rx_phase;
  logic tx_phase;
  logic [2:0] data_bytes;
  logic access;
  logic wr;
  logic mapped;
  logic idle;
  logic go_accept;
  logic [31:0] rd_val;

  assign idle = (state_reg == sfq_pkg::SFQ_IDLE);
  assign access = psel_in && penable_in;
  assign wr = access && pwrite_in;
  assign go_accept = wr && (paddr_in == sfq_pkg::OFF_GO) && idle;
  assign mapped = (paddr_in == sfq_pkg::OFF_CTRL)
    || (paddr_in == sfq_pkg::OFF_ADDR) || (paddr_in == sfq_pkg::OFF_MODE)
    || (paddr_in == sfq_pkg::OFF_WDATA) || (paddr_in == sfq_pkg::OFF_RDATA)
    || (paddr_in == sfq_pkg::OFF_STATUS) || (paddr_in == sfq_pkg::OFF_GO);
  assign pready_out = 1'b1;
  assign pslverr_out = access && !mapped;
  assign prdata_out = prdata_reg;
  assign cs_n_out = cs_n_reg;
  assign sclk_out = sclk_reg;
  assign data_line_out = out_reg;
  assign data_line_oe_n_out = oe_n_reg;

  // program data: at most four bytes a command, longer pages chained
  assign data_bytes = (ctrl_reg.data_bytes > sfq_pkg::MAX_DATA_BYTES)
    ? sfq_pkg::MAX_DATA_BYTES : ctrl_reg.data_bytes;

  // software registers; settings are frozen while a command runs
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_reg <= sfq_pkg::CTRL_RESET;
      addr_reg <= sfq_pkg::ADDR_RESET;
      mode_reg <= sfq_pkg::MODE_RESET;
      wdata_reg <= sfq_pkg::WDATA_RESET;
    end
    else if (wr && idle)
    begin
      unique case (paddr_in)
        sfq_pkg::OFF_CTRL: ctrl_reg <= pwdata_in;
        sfq_pkg::OFF_ADDR: addr_reg <= pwdata_in[23:0];
        sfq_pkg::OFF_MODE: mode_reg <= pwdata_in[7:0];
        sfq_pkg::OFF_WDATA: wdata_reg <= pwdata_in;
        default: ;
      endcase
    end
  end

  // done flag: completion wins over a write-one clear
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      done_reg <= 1'b0;
    else if (done_pulse_reg)
      done_reg <= 1'b1;
    else if (wr && paddr_in == sfq_pkg::OFF_STATUS
        && pwdata_in[sfq_pkg::STAT_DONE_BIT])
      done_reg <= 1'b0;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (paddr_in)
      sfq_pkg::OFF_CTRL: rd_val = ctrl_reg;
      sfq_pkg::OFF_ADDR: rd_val = {8'h00, addr_reg};
      sfq_pkg::OFF_MODE: rd_val = {24'h00_0000, mode_reg};
      sfq_pkg::OFF_WDATA: rd_val = wdata_reg;
      sfq_pkg::OFF_RDATA: rd_val = rx_reg;
      sfq_pkg::OFF_STATUS:
      begin
        rd_val[sfq_pkg::STAT_BUSY_BIT] = !idle;
        rd_val[sfq_pkg::STAT_DONE_BIT] = done_reg;
        rd_val[sfq_pkg::STAT_SELECT_BIT] = !cs_n_reg;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      prdata_reg <= 32'h0000_0000;
    else if (psel_in && !penable_in && !pwrite_in)
      prdata_reg <= rd_val;
  end

  // data lines come from the pins: two-stage synchroniser
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      line_meta_reg <= 4'h0;
      line_sync_reg <= 4'h0;
    end
    else
    begin
      line_meta_reg <= data_line_in;
      line_sync_reg <= line_meta_reg;
    end
  end

  // half-period divider for the serial clock
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      div_reg <= 4'h0;
    else if (idle || tick)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end
  assign tick = (div_reg == 4'(sfq_pkg::SCLK_HALF_CYCLES - 1));

  // lines per beat for the current phase
  always_comb
  begin
    logic [1:0] code;
    code = sfq_pkg::LANES_1;
    unique case (state_reg)
      sfq_pkg::SFQ_OPC: code = ctrl_reg.cmd_lanes;
      sfq_pkg::SFQ_ADDR, sfq_pkg::SFQ_MODE:
        code = ctrl_reg.addr_lanes;
      sfq_pkg::SFQ_DATA, sfq_pkg::SFQ_DUMMY:
        code = ctrl_reg.data_lanes;
      default: code = sfq_pkg::LANES_1;
    endcase
    unique case (code)
      sfq_pkg::LANES_1: lanes = 6'h01;
      sfq_pkg::LANES_2: lanes = 6'h02;
      default: lanes = 6'h04;
    endcase
  end

  // opcode and dummy always single rate; address, mode and data on both edges when set
  assign dtr_phase = ctrl_reg.dtr && (state_reg == sfq_pkg::SFQ_ADDR
    || state_reg == sfq_pkg::SFQ_MODE
    || state_reg == sfq_pkg::SFQ_DATA);
  assign rx_phase = (state_reg == sfq_pkg::SFQ_DATA) && !ctrl_reg.host_sends;
  assign tx_phase = (state_reg == sfq_pkg::SFQ_OPC)
    || (state_reg == sfq_pkg::SFQ_ADDR) || (state_reg == sfq_pkg::SFQ_MODE)
    || (state_reg == sfq_pkg::SFQ_DATA && ctrl_reg.host_sends);

  // phase that follows the current one, then what it loads
  always_comb
  begin
    logic early;
    logic pre_mode;
    logic pre_dummy;
    early = (state_reg == sfq_pkg::SFQ_START)
      || (state_reg == sfq_pkg::SFQ_OPC);
    pre_mode = early || (state_reg == sfq_pkg::SFQ_ADDR);
    pre_dummy = pre_mode || (state_reg == sfq_pkg::SFQ_MODE);
    if (state_reg == sfq_pkg::SFQ_START && !ctrl_reg.skip_opcode)
      state_next = sfq_pkg::SFQ_OPC;
    else if (early && ctrl_reg.has_addr)
      state_next = sfq_pkg::SFQ_ADDR;
    else if (pre_mode && ctrl_reg.has_mode)
      state_next = sfq_pkg::SFQ_MODE;
    else if (pre_dummy && ctrl_reg.dummy_clks != 5'h00)
      state_next = sfq_pkg::SFQ_DUMMY;
    else if (state_reg != sfq_pkg::SFQ_DATA && data_bytes != 3'h0)
      state_next = sfq_pkg::SFQ_DATA;
    else
      state_next = sfq_pkg::SFQ_FIN;
    shift_next = 32'h0000_0000;
    bits_next = 6'h00;
    unique case (state_next)
      sfq_pkg::SFQ_OPC:
      begin
        shift_next = {ctrl_reg.opcode, 24'h00_0000};
        bits_next = sfq_pkg::OPCODE_BITS;
      end
      sfq_pkg::SFQ_ADDR:
      begin
        shift_next = {addr_reg, 8'h00};
        bits_next = sfq_pkg::ADDR_BITS;
      end
      sfq_pkg::SFQ_MODE:
      begin
        shift_next = {mode_reg, 24'h00_0000};
        bits_next = sfq_pkg::MODE_BITS;
      end
      sfq_pkg::SFQ_DUMMY: bits_next = {1'b0, ctrl_reg.dummy_clks};
      sfq_pkg::SFQ_DATA:
      begin
        shift_next = wdata_reg;
        bits_next = {data_bytes, 3'h0};
      end
      default: ;
    endcase
  end

  // incoming beat, most significant lines first
  always_comb
  begin
    unique case (lanes)
      6'h01: rx_next = {rx_reg[30:0], line_sync_reg[1]};
      6'h02: rx_next = {rx_reg[29:0], line_sync_reg[1:0]};
      default: rx_next = {rx_reg[27:0], line_sync_reg};
    endcase
  end

  // command sequencer, stepped on each half period of the serial clock
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= sfq_pkg::SFQ_IDLE;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      shift_reg <= 32'h0000_0000;
      bits_reg <= 6'h00;
      rx_reg <= 32'h0000_0000;
      done_pulse_reg <= 1'b0;
    end
    else
    begin
      done_pulse_reg <= 1'b0;
      unique case (state_reg)
        sfq_pkg::SFQ_IDLE:
          if (go_accept)
          begin
            state_reg <= sfq_pkg::SFQ_START;
            cs_n_reg <= 1'b0;
          end
        sfq_pkg::SFQ_START:
          if (tick)
          begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
          end
        sfq_pkg::SFQ_FIN:
          if (tick)
          begin
            if (sclk_reg)
              sclk_reg <= 1'b0;
            else
            begin
              state_reg <= sfq_pkg::SFQ_IDLE;
              cs_n_reg <= !ctrl_reg.keep_select;
              done_pulse_reg <= 1'b1;
            end
          end
        sfq_pkg::SFQ_DUMMY:
          if (tick)
          begin
            sclk_reg <= !sclk_reg;
            if (sclk_reg && bits_reg == 6'h01)
            begin
              state_reg <= state_next;
              shift_reg <= shift_next;
              bits_reg <= bits_next;
            end
            else if (sclk_reg)
              bits_reg <= bits_reg - 6'h01;
          end
        sfq_pkg::SFQ_OPC, sfq_pkg::SFQ_ADDR, sfq_pkg::SFQ_MODE,
        sfq_pkg::SFQ_DATA:
          if (tick)
          begin
            sclk_reg <= !sclk_reg;
            if (rx_phase && (dtr_phase || !sclk_reg))
              rx_reg <= rx_next;
            if (dtr_phase || sclk_reg)
            begin
              if (bits_reg <= lanes)
              begin
                state_reg <= state_next;
                shift_reg <= shift_next;
                bits_reg <= bits_next;
              end
              else
              begin
                shift_reg <= shift_reg << lanes;
                bits_reg <= bits_reg - lanes;
              end
            end
          end
      endcase
    end
  end

  // pin drive; lines 2 and 3 held high while selected outside four-line phases
  always_comb
  begin
    out_val = 4'hC;
    oe_n_val = 4'hF;
    if (!cs_n_reg && lanes != 6'h04)
      oe_n_val[3:2] = 2'h0;
    if (tx_phase)
    begin
      unique case (lanes)
        6'h01:
        begin
          out_val[0] = shift_reg[31];
          oe_n_val[0] = 1'b0;
        end
        6'h02:
        begin
          out_val[1:0] = shift_reg[31:30];
          oe_n_val[1:0] = 2'h0;
        end
        default:
        begin
          out_val = shift_reg[31:28];
          oe_n_val = 4'h0;
        end
      endcase
    end
  end

  // quad dummy clocks leave every line released
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_reg <= 4'hC;
      oe_n_reg <= 4'hF;
    end
    else
    begin
      out_reg <= out_val;
      oe_n_reg <= oe_n_val;
    end
  end

endmodule : sfq_host

// *** rtl/sfq_pkg.sv ***
// constants, types and register map of the quad serial flash host
// How it works
// - four-wire opcode: two nibble clocks, high first
// - C0h parameter upper nibble sets dummy clocks
// - program sends 1 to 256 data bytes; the host sends at most 4 a command
// - security register address 00h, 10h/20h/30h, offset
// - dual address: odd bits line 1
// - quad address: four bits per clock, MSB line 3
// - quad data: two clocks per byte
// - wrap bits on lines 0-2, seventh clock
// - mode byte upper nibble F unless continuous
// - single double-rate read: 4 clocks per byte
// - dual/quad double-rate reads: 2 or 1 clocks
// - four-wire double-rate reads: 1 clock per byte
// - all bytes most significant bit first
package sfq_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_NS = 16;
  localparam int SCLK_HALF_CYCLES =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_GO = 8'h18;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_SELECT_BIT = 2;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [23:0] ADDR_RESET = 24'h00_0000;
  localparam logic [7:0] MODE_RESET = 8'hFF;
  localparam logic [31:0] WDATA_RESET = 32'h0000_0000;

  localparam logic [1:0] LANES_1 = 2'h0;
  localparam logic [1:0] LANES_2 = 2'h1;
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [2:0] MAX_DATA_BYTES = 3'h4;

  localparam logic [7:0] OP_SET_READ_PARAMS = 8'hC0;
  localparam logic [7:0] OP_BURST_WRAP_READ = 8'h0C;
  localparam logic [7:0] OP_DTR_FAST_READ = 8'h0D;
  localparam logic [7:0] OP_DTR_DUAL_READ = 8'hBD;
  localparam logic [7:0] OP_DTR_QUAD_READ = 8'hED;
  localparam logic [7:0] OP_DTR_WRAP_READ = 8'h0E;
  localparam logic [7:0] OP_SET_BURST_WRAP = 8'h77;

  typedef struct packed {
    logic [2:0] spare_hi;
    logic [4:0] dummy_clks;
    logic spare_lo;
    logic [2:0] data_bytes;
    logic skip_opcode;
    logic keep_select;
    logic host_sends;
    logic dtr;
    logic has_mode;
    logic has_addr;
    logic [1:0] data_lanes;
    logic [1:0] addr_lanes;
    logic [1:0] cmd_lanes;
    logic [7:0] opcode;
  } sfq_ctrl_s;

  typedef enum logic [2:0] {
    SFQ_IDLE, SFQ_START, SFQ_OPC, SFQ_ADDR,
    SFQ_MODE, SFQ_DUMMY, SFQ_DATA, SFQ_FIN
  } sfq_phase_e;

endpackage : sfq_pkg

// *** sim/sfq_flash_model.sv ***
// behavioural four-wire flash device facing the host
`timescale 1ns/100ps
module sfq_flash_model (
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] data_line_in,
  output logic [3:0] data_line_out,
  output logic [3:0] data_line_oe_n_out
);
  logic [7:0] op_reg = 8'h00;
  logic write_enable_latch = 1'b0;
  logic low_nib = 1'b0;
  logic [7:0] stat;
  int beat = 0;
  assign stat = {6'h00, write_enable_latch, 1'b0};
  always @(posedge sclk_in or posedge cs_n_in)
    if (cs_n_in)
      beat <= 0;
    else
    begin
      if (beat < 2)
        op_reg <= {op_reg[3:0], data_line_in};
      beat <= beat + 1;
      if (beat == 1)
        case ({op_reg[3:0], data_line_in})
          8'h06: write_enable_latch <= 1'b1;
          8'h04: write_enable_latch <= 1'b0;
          default: ; // no bytes taken, no state change
        endcase
    end
  // status byte repeats, high nibble first, until deselect
  always @(negedge sclk_in or posedge cs_n_in)
    if (cs_n_in)
    begin
      data_line_oe_n_out <= 4'hF;
      data_line_out <= 4'h0;
      low_nib <= 1'b0;
    end
    else if (beat >= 2 && op_reg == 8'h05)
    begin
      data_line_oe_n_out <= 4'h0;
      data_line_out <= low_nib ? stat[3:0] : stat[7:4];
      low_nib <= ~low_nib;
    end
endmodule : sfq_flash_model

// *** sim/sfq_host_chk.sv ***
// assertions on the ports of the quad flash host
`timescale 1ns/100ps
module sfq_host_chk (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cs_n_out,
  input wire logic sclk_out,
  input wire logic [3:0] data_line_out,
  input wire logic [3:0] data_line_oe_n_out
);
  sfq_pkg::sfq_ctrl_s ctl_reg;
  logic mapped;
  assign mapped = paddr_in[1:0] == 2'h0 && paddr_in <= sfq_pkg::OFF_GO;
  // command word as last written while deselected
  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
      ctl_reg <= '0;
    else if (cs_n_out && psel_in && penable_in && pwrite_in &&
             paddr_in == sfq_pkg::OFF_CTRL)
      ctl_reg <= sfq_pkg::sfq_ctrl_s'(pwdata_in);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  a_pready_high: assert property (pready_out == 1'b1)
    else $error("pready low");
  a_slverr_map: assert property (psel_in && penable_in |->
    pslverr_out == !mapped) else $error("pslverr does not match map");
  a_rdata_unmapped: assert property (psel_in && !penable_in &&
    !pwrite_in && !mapped |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read data not zero");
  a_sclk_half: assert property ($rose(sclk_out) |->
    sclk_out [*4] ##1 !sclk_out) else $error("sclk high time wrong");
  a_select_lead: assert property ($fell(cs_n_out) |->
    (!sclk_out) [*8] ##1 sclk_out) else $error("first sclk rise late");
  a_cs_edge: assert property ($changed(cs_n_out) |->
    !sclk_out && !$past(sclk_out)) else $error("select moved near sclk");
  a_idle_release: assert property (cs_n_out && $past(cs_n_out) |->
    data_line_oe_n_out == 4'hF) else $error("lines driven while idle");
  a_quad_opcode: assert property (
    $fell(cs_n_out) && ctl_reg.cmd_lanes[1] && !ctl_reg.skip_opcode |->
    ##8 (data_line_out == ctl_reg.opcode[7:4] && sclk_out &&
    data_line_oe_n_out == 4'h0) ##8 (data_line_out == ctl_reg.opcode[3:0]))
    else $error("opcode nibbles wrong");
endmodule : sfq_host_chk

bind sfq_host sfq_host_chk sfq_host_chk_i (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .cs_n_out(cs_n_out), .sclk_out(sclk_out),
  .data_line_out(data_line_out), .data_line_oe_n_out(data_line_oe_n_out)
);

// *** sim/sfq_host_tb.sv ***
// self-checking bench for the quad flash host
`timescale 1ns/100ps
module sfq_host_tb;
  typedef struct packed {
    logic [7:0] op;
    logic [2:0] n;
    logic [31:0] exp;
  } sfq_row_s;
  logic clock_in = 1'b0, reset_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out, q;
  logic pready_out, pslverr_out, cs_n_out, sclk_out, e;
  logic [3:0] host_q, host_oe_n, dev_q, dev_oe_n, wire_q;
  logic [3:0] last_q = 4'h0;
  int err_count = 0;
  int tests_run = 0;
  sfq_row_s rows [13] = '{'{8'h05, 3'h1, 32'h0}, '{8'h06, 3'h0, 32'h0},
    '{8'h05, 3'h2, 32'h0202}, '{8'h3C, 3'h0, 32'h0}, '{8'h05, 3'h1, 32'h02},
    '{8'h75, 3'h0, 32'h0}, '{8'h7A, 3'h0, 32'h0}, '{8'h50, 3'h0, 32'h0},
    '{8'h05, 3'h3, 32'h02_0202}, '{8'h04, 3'h0, 32'h0},
    '{8'h05, 3'h1, 32'h0}, '{8'h06, 3'h0, 32'h0},
    '{8'h05, 3'h7, 32'h0202_0202}};
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rvals [6] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0};
  sfq_host sfq_host_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cs_n_out(cs_n_out), .sclk_out(sclk_out), .data_line_in(wire_q),
    .data_line_out(host_q), .data_line_oe_n_out(host_oe_n));
  sfq_flash_model sfq_flash_model_i (.cs_n_in(cs_n_out),
    .sclk_in(sclk_out), .data_line_in(wire_q), .data_line_out(dev_q),
    .data_line_oe_n_out(dev_oe_n));
  // undriven lines show a changing level
  always_comb
    for (int i = 0; i < 4; i++)
      wire_q[i] = !host_oe_n[i] ? host_q[i] :
                  !dev_oe_n[i] ? dev_q[i] : ~last_q[i];
  always @(posedge clock_in)
    last_q <= wire_q;
  always #2 clock_in = ~clock_in;
  task automatic give_verdict;
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1 && n < 20)
    begin
      @(posedge clock_in);
      n++;
    end
    if (n == 20)
    begin
      err_count++;
      give_verdict();
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic start(input logic [7:0] op, input logic [2:0] n);
    apb(1'b1, sfq_pkg::OFF_CTRL, {9'h000, n, 12'h022, op});
    apb(1'b1, sfq_pkg::OFF_GO, 32'h0000_0001);
    apb(1'b0, sfq_pkg::OFF_STATUS, 32'h0000_0000);
    chk({31'h0, q[sfq_pkg::STAT_BUSY_BIT]}, 32'h0000_0001);
  endtask : start
  task automatic wait_idle;
    int k = 0;
    do
    begin
      apb(1'b0, sfq_pkg::OFF_STATUS, 32'h0000_0000);
      k++;
    end
    while (q[sfq_pkg::STAT_BUSY_BIT] !== 1'b0 && k < 100);
    if (k == 100)
    begin
      err_count++;
      give_verdict();
    end
    apb(1'b0, sfq_pkg::OFF_STATUS, 32'h0000_0000);
    chk({31'h0, q[sfq_pkg::STAT_DONE_BIT]}, 32'h0000_0001);
  endtask : wait_idle
  function automatic logic [31:0] mask(input logic [2:0] n);
    return (n >= 3'h4) ? 32'hFFFF_FFFF : (32'h1 << (8 * n)) - 32'h1;
  endfunction : mask
  initial
  begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    foreach (rows[r])
    begin
      start(rows[r].op, rows[r].n);
      wait_idle();
      if (rows[r].n != 3'h0)
      begin
        apb(1'b0, sfq_pkg::OFF_RDATA, 32'h0000_0000);
        chk(q & mask(rows[r].n), rows[r].exp);
      end
    end
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h0000_0001);
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk(q, rvals[i]);
    end
    start(8'h06, 3'h0);
    apb(1'b1, sfq_pkg::OFF_ADDR, 32'h0012_3456);
    wait_idle();
    apb(1'b0, sfq_pkg::OFF_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1'b1, sfq_pkg::OFF_STATUS, 32'h0000_0002);
    apb(1'b0, sfq_pkg::OFF_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    give_verdict();
  end
endmodule : sfq_host_tb
